/* File: scc_pkg.sv */
// Summary of operation
// - serial strap high, hardware_software_select low: register ranges
// - pins in hardware modes, register in software
// - changes accepted anytime, applied after one acquisition
// - settings relatch in operation, no reset needed
// - mode limits start rate: 1M/800k/670k SPS
// - result belongs to sample of same conversion
// - convert only after acquisition and start low
// - binary search msb first, fourteen steps
// - form code, then drop busy
// - result word is fourteen bits
// - fast/low-power pins decode, equal means normal
`timescale 1ns/1ps

package scc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int RATE_FAST_KSPS = 1000;
  localparam int RATE_NORMAL_KSPS = 800;
  localparam int RATE_LOWPWR_KSPS = 670;
  // least start spacing, rounded up to whole cycles
  localparam int PER_FAST_CYC =
    (CLK_MHZ * 1000 + RATE_FAST_KSPS - 1) / RATE_FAST_KSPS;
  localparam int PER_NORMAL_CYC =
    (CLK_MHZ * 1000 + RATE_NORMAL_KSPS - 1) / RATE_NORMAL_KSPS;
  localparam int PER_LOWPWR_CYC =
    (CLK_MHZ * 1000 + RATE_LOWPWR_KSPS - 1) / RATE_LOWPWR_KSPS;
  localparam int T_ACQ_NS = 250;
  localparam int ACQ_CYC = (T_ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int T_BIT_NS = 40;
  localparam int BIT_CYC = (T_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int T_IDLE_GAP_US = 1000;
  localparam int IDLE_GAP_CYC = T_IDLE_GAP_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int RES_W = 14;
  localparam int IDX_W = 4;
  localparam int PER_W = 8;
  localparam int BIT_W = 4;
  localparam int GAP_W = 24;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam int CFG_BIPOLAR = 0;
  localparam int CFG_TEN = 1;
  localparam int CFG_MODE_LSB = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_VALID = 1;
  localparam int STAT_STALE = 2;
  localparam int STAT_SRC_SW = 3;
  localparam int STAT_CFG_LSB = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCC_MODE_NORMAL = 2'b00,
    SCC_MODE_FAST = 2'b01,
    SCC_MODE_LOWPWR = 2'b10,
    SCC_MODE_NORMAL2 = 2'b11
  } scc_mode_e;

  typedef struct packed {
    scc_mode_e mode;
    logic ten;
    logic bipolar;
  } scc_cfg_s;

  localparam scc_cfg_s CFG_RST = 4'h0;

  typedef enum logic [1:0] {
    SCC_ST_ACQ = 2'b00,
    SCC_ST_CONV = 2'b01,
    SCC_ST_DONE = 2'b10
  } scc_state_e;

endpackage : scc_pkg

// two-stage synchroniser for pins, one per bit
module scc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : scc_sync

/* File: scc_top.sv */
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

module scc_top
  import scc_pkg::*;
#(
  parameter int IDLE_GAP = IDLE_GAP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // straps and configuration pins
  input wire logic serial_parallel_select_i,
  input wire logic hardware_software_select_i,
  input wire logic bipolar_i,
  input wire logic ten_i,
  input wire logic fast_i,
  input wire logic low_power_i,
  // conversion control
  input wire logic convert_start_n_i,
  input wire logic comp_i,
  output logic busy_o,
  output logic track_o,
  output logic [RES_W-1:0] dac_code_o,
  output logic [RES_W-1:0] result_o,
  output scc_cfg_s cfg_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pins_raw;
  logic [6:0] pins_s;
  logic sp_s;
  logic hs_s;
  logic bip_s;
  logic ten_s;
  logic fast_s;
  logic lp_s;
  logic cnv_n_s;

  // start pin inverted so the synchroniser reset level is its idle level,
  // otherwise the first edge after reset looks like a start request
  assign pins_raw = {~convert_start_n_i, low_power_i, fast_i, ten_i,
                     bipolar_i, hardware_software_select_i,
                     serial_parallel_select_i};

  scc_sync #(
    .W(7)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  assign sp_s = pins_s[0];
  assign hs_s = pins_s[1];
  assign bip_s = pins_s[2];
  assign ten_s = pins_s[3];
  assign fast_s = pins_s[4];
  assign lp_s = pins_s[5];
  assign cnv_n_s = ~pins_s[6];

  // ---------------------------------------------------------------
  // configuration source select
  // ---------------------------------------------------------------
  scc_cfg_s sw_cfg_q;
  scc_cfg_s pin_cfg;
  scc_cfg_s sel_cfg;
  scc_cfg_s act_cfg_q;
  logic src_sw;

  always_comb begin
    pin_cfg.bipolar = bip_s;
    pin_cfg.ten = ten_s;
    // equal pins select normal
    if (fast_s && !lp_s) begin
      pin_cfg.mode = SCC_MODE_FAST;
    end else if (lp_s && !fast_s) begin
      pin_cfg.mode = SCC_MODE_LOWPWR;
    end else begin
      pin_cfg.mode = SCC_MODE_NORMAL;
    end
  end

  assign src_sw = sp_s && !hs_s;
  assign sel_cfg = src_sw ? sw_cfg_q : pin_cfg;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic wb_req;
  logic wb_wr;
  logic valid_q;
  logic stale_q;
  logic [RES_W-1:0] result_q;
  scc_state_e state_q;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // software configuration, accepted at any time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_cfg_q <= CFG_RST;
    end else if (wb_wr && wb_adr_i == REG_CFG && wb_sel_i[0]) begin
      sw_cfg_q.bipolar <= wb_dat_i[CFG_BIPOLAR];
      sw_cfg_q.ten <= wb_dat_i[CFG_TEN];
      sw_cfg_q.mode <= scc_mode_e'(wb_dat_i[CFG_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        REG_CFG: begin
          wb_dat_o <= {28'h000_0000, sw_cfg_q};
        end
        REG_STATUS: begin
          wb_dat_o <= {24'h00_0000, act_cfg_q, src_sw, stale_q,
                       valid_q, busy_o};
        end
        REG_RESULT: begin
          wb_dat_o <= {18'h0_0000, result_q};
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // start rate and acquisition timing
  // ---------------------------------------------------------------
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] per_min;
  logic [PER_W-1:0] acq_cnt_q;
  logic acq_done;
  logic cnv_n_d1_q;
  logic start_fall;
  logic start;

  always_comb begin
    case (act_cfg_q.mode)
      SCC_MODE_FAST: begin
        per_min = PER_W'(PER_FAST_CYC);
      end
      SCC_MODE_LOWPWR: begin
        per_min = PER_W'(PER_LOWPWR_CYC);
      end
      default: begin
        per_min = PER_W'(PER_NORMAL_CYC);
      end
    endcase
  end

  // spacing counter saturates once the slowest period has passed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_cnt_q <= PER_W'(PER_LOWPWR_CYC);
    end else if (start) begin
      per_cnt_q <= PER_W'(1);
    end else if (per_cnt_q < PER_W'(PER_LOWPWR_CYC)) begin
      per_cnt_q <= per_cnt_q + PER_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acq_cnt_q <= PER_W'(ACQ_CYC);
    end else if (state_q != SCC_ST_ACQ) begin
      acq_cnt_q <= '0;
    end else if (acq_cnt_q < PER_W'(ACQ_CYC)) begin
      acq_cnt_q <= acq_cnt_q + PER_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnv_n_d1_q <= 1'b1;
    end else begin
      cnv_n_d1_q <= cnv_n_s;
    end
  end

  // an early falling edge is dropped, not deferred
  assign acq_done = state_q == SCC_ST_ACQ &&
                    acq_cnt_q >= PER_W'(ACQ_CYC) &&
                    per_cnt_q >= per_min;
  assign start_fall = cnv_n_d1_q && !cnv_n_s;
  assign start = start_fall && acq_done;

  // ---------------------------------------------------------------
  // configuration latch
  // ---------------------------------------------------------------
  // taken at sampling, so a change lands after one acquisition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_cfg_q <= CFG_RST;
    end else if (start) begin
      act_cfg_q <= sel_cfg;
    end
  end

  // ---------------------------------------------------------------
  // successive approximation
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] idx_q;
  logic [BIT_W-1:0] bit_cnt_q;
  logic [RES_W-1:0] trial_q;
  logic bit_end;

  assign bit_end = bit_cnt_q == BIT_W'(BIT_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SCC_ST_ACQ;
    end else begin
      case (state_q)
        SCC_ST_ACQ: begin
          if (start) begin
            state_q <= SCC_ST_CONV;
          end
        end
        SCC_ST_CONV: begin
          if (bit_end && idx_q == '0) begin
            state_q <= SCC_ST_DONE;
          end
        end
        SCC_ST_DONE: begin
          state_q <= SCC_ST_ACQ;
        end
        default: begin
          state_q <= SCC_ST_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_q <= '0;
    end else if (state_q != SCC_ST_CONV || bit_end) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + BIT_W'(1);
    end
  end

  // msb first: half scale trial, keep or clear on comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= '0;
      trial_q <= '0;
    end else if (start) begin
      idx_q <= IDX_W'(RES_W - 1);
      trial_q <= {1'b1, {(RES_W-1){1'b0}}};
    end else if (state_q == SCC_ST_CONV && bit_end) begin
      trial_q[idx_q] <= comp_i;
      if (idx_q != '0) begin
        trial_q[idx_q - IDX_W'(1)] <= 1'b1;
        idx_q <= idx_q - IDX_W'(1);
      end
    end
  end

  // code formed first, busy falls one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= '0;
      valid_q <= 1'b0;
    end else if (state_q == SCC_ST_CONV && bit_end && idx_q == '0) begin
      result_q <= {trial_q[RES_W-1:1], comp_i};
      valid_q <= 1'b1;
    end else if (start) begin
      valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (start) begin
      busy_o <= 1'b1;
    end else if (state_q == SCC_ST_DONE) begin
      busy_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // idle gap watch for fast mode
  // ---------------------------------------------------------------
  logic [GAP_W-1:0] gap_cnt_q;
  logic gap_over_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_cnt_q <= '0;
      gap_over_q <= 1'b1;
    end else if (start) begin
      gap_cnt_q <= '0;
      gap_over_q <= 1'b0;
    end else if (gap_cnt_q >= GAP_W'(IDLE_GAP)) begin
      gap_over_q <= 1'b1;
    end else begin
      gap_cnt_q <= gap_cnt_q + GAP_W'(1);
    end
  end

  // flags a result the host should discard
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stale_q <= 1'b0;
    end else if (start) begin
      stale_q <= gap_over_q && sel_cfg.mode == SCC_MODE_FAST;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      track_o <= 1'b1;
      dac_code_o <= '0;
      result_o <= '0;
      cfg_o <= CFG_RST;
    end else begin
      track_o <= state_q == SCC_ST_ACQ && !start;
      dac_code_o <= trial_q;
      result_o <= result_q;
      cfg_o <= act_cfg_q;
    end
  end

endmodule : scc_top

/* File: scc_top_assertions.sv */
`timescale 1ns/1ps

module scc_top_assertions
  import scc_pkg::*;
#(
  parameter int IDLE_GAP = IDLE_GAP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic busy_o,
  input wire logic track_o,
  input wire logic [RES_W-1:0] dac_code_o,
  input wire logic [RES_W-1:0] result_o,
  input wire scc_cfg_s cfg_o
);
  logic [7:0] bcnt_q;
  logic [7:0] tcnt_q;
  logic [7:0] scnt_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  always_ff @(posedge clk_i) begin
    bcnt_q <= (rst_i || !busy_o) ? 8'h00 : bcnt_q + 8'h01;
  end
  // saturate at reset: acquisition counts as already complete
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcnt_q <= 8'hFF;
    end else if (!track_o) begin
      tcnt_q <= 8'h00;
    end else if (tcnt_q != 8'hFF) begin
      tcnt_q <= tcnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scnt_q <= 8'hFF;
    end else if (busy_o && bcnt_q == 8'h00) begin
      scnt_q <= 8'h01;
    end else if (scnt_q != 8'hFF) begin
      scnt_q <= scnt_q + 8'h01;
    end
  end

  a_busy_length: assert property (
    $fell(busy_o) |-> bcnt_q == 8'h47) else $error("busy length wrong");
  a_busy_track: assert property (
    $rose(busy_o) |-> !track_o) else $error("track high in conversion");
  a_track_idle: assert property (
    busy_o |-> !track_o) else $error("track and busy together");
  a_msb_first: assert property (
    $rose(busy_o) |-> ##[0:1] dac_code_o == 14'h2000)
    else $error("first trial not msb");
  a_result_hold: assert property (
    busy_o && $past(busy_o) |-> $stable(result_o))
    else $error("result moved in conversion");
  a_acq_before: assert property (
    $rose(busy_o) |-> tcnt_q >= 8'h1F) else $error("acquisition cut short");
  a_start_space: assert property (
    $rose(busy_o) |-> scnt_q >= PER_FAST_CYC) else $error("starts too close");
  a_cfg_at_start: assert property (
    !$stable(cfg_o) |-> ##[0:1] busy_o) else $error("cfg moved off start");
  a_ack_follows: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
endmodule : scc_top_assertions

bind scc_top scc_top_assertions #(.IDLE_GAP(IDLE_GAP)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .busy_o(busy_o), .track_o(track_o),
  .dac_code_o(dac_code_o), .result_o(result_o), .cfg_o(cfg_o)
);

/* File: scc_host_model.sv */
`timescale 1ns/1ps

module scc_host_model
  import scc_pkg::*;
(
  // clock and request
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [RES_W-1:0] sample_i,
  // converter side
  input wire logic [RES_W-1:0] dac_code_i,
  output logic convert_start_n_o,
  output logic comp_o
);
  logic [RES_W-1:0] held_q = '0;
  logic [2:0] low_q = 3'h0;

  // input frozen at start, so the code must belong to this sample
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      held_q <= sample_i;
    end
  end
  // held low long enough for the pin synchroniser
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      low_q <= 3'h4;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
  end
  assign convert_start_n_o = (low_q == 3'h0);
  assign comp_o = (held_q >= dac_code_i);
endmodule : scc_host_model

/* File: test_sar_conversion_control.sv */
`timescale 1ns/1ps

module test_sar_conversion_control
  import scc_pkg::*;
;
  localparam logic [13:0] SMP [4] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_rdat;
  logic ser = 1'b0, hws = 1'b0, bip = 1'b0, ten = 1'b0;
  logic fast = 1'b0, lowp = 1'b0, go = 1'b0, cs_n, comp, busy, track;
  logic [13:0] smp = 14'h0, dac, res;
  scc_cfg_s cfg;
  int fail_count = 0;
  int n_checks = 0;

  scc_top #(.IDLE_GAP(200)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .serial_parallel_select_i(ser),
    .hardware_software_select_i(hws), .bipolar_i(bip), .ten_i(ten),
    .fast_i(fast), .low_power_i(lowp), .convert_start_n_i(cs_n),
    .comp_i(comp), .busy_o(busy), .track_o(track), .dac_code_o(dac),
    .result_o(res), .cfg_o(cfg)
  );
  scc_host_model i_host (
    .clk_i(clk_i), .go_i(go), .sample_i(smp), .dac_code_i(dac),
    .convert_start_n_o(cs_n), .comp_o(comp)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  // values read right after the edge are the ones the edge sampled
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge clk_i);
      if (sig === lvl)
        return;
    end
    fail_count++;
    test_done();
  endtask : wait_for

  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wait_for(wb_ack, 1'b1, 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic conv(input logic [13:0] s, input int gap);
    logic [31:0] q;
    smp <= s;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    wait_for(busy, 1'b1, 20);
    wait_for(busy, 1'b0, 100);
    chk("result", {18'h0, res}, {18'h0, s});
    wb(1'b0, REG_RESULT, 32'h0, q);
    chk("rd result", q, {18'h0, s});
    repeat (gap) @(posedge clk_i);
  endtask : conv

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [31:0] q;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("idle after reset", {31'h0, busy}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      {fast, lowp} <= i[1:0];
      {ten, bip} <= i[1:0];
      repeat (8) @(posedge clk_i);
      conv(SMP[i], PER_LOWPWR_CYC);
      chk("mode", {30'h0, cfg.mode == SCC_MODE_FAST,
        cfg.mode == SCC_MODE_LOWPWR}, {30'h0, i == 2, i == 1});
      chk("range", {30'h0, cfg.ten, cfg.bipolar}, 32'(i));
      wb(1'b0, REG_STATUS, 32'h0, q);
      chk("stale", {31'h0, q[STAT_STALE]}, {31'h0, i == 2});
    end
    // second start well inside the spacing must be dropped
    conv(14'h0AAA, 0);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk("early start", {31'h0, busy}, 32'h0);
    repeat (PER_LOWPWR_CYC) @(posedge clk_i);
    ser <= 1'b1;
    wb(1'b1, REG_CFG, 32'h0000_000B, q);
    wb(1'b0, REG_CFG, 32'h0, q);
    chk("cfg readback", q, 32'h0000_000B);
    wb(1'b0, 4'hC, 32'h0, q);
    chk("unmapped", q, 32'h0);
    conv(14'h1555, PER_LOWPWR_CYC);
    chk("sw cfg", {28'h0, cfg}, 32'h0000_000B);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("status", q, 32'h0000_00BA);
    hws <= 1'b1;
    {fast, lowp, ten, bip} <= 4'h8;
    repeat (8) @(posedge clk_i);
    conv(14'h2AAA, PER_LOWPWR_CYC);
    chk("hw cfg", {28'h0, cfg}, 32'h0000_0004);
    test_done();
  end
endmodule : test_sar_conversion_control
